// [serial_link_config_regs.svh]
`ifndef SERIAL_LINK_CONFIG_REGS_SVH
`define SERIAL_LINK_CONFIG_REGS_SVH

// ==========================================
// Register offsets.
`define OFS_PROTOCOL 8'h00
`define OFS_STATION 8'h04
`define OFS_RATE 8'h08
`define OFS_STOP 8'h0c
`define OFS_PARITY 8'h10
`define OFS_TIMEOUT 8'h14
`define OFS_DELAY 8'h18
`define OFS_GAP 8'h1c
`define OFS_ACTIVE 8'h20
`define OFS_LINK 8'h24
`define OFS_IRQ_STAT 8'h28
`define OFS_IRQ_MASK 8'h2c

// ==========================================
// Reset values and legal ranges.
`define RST_PROTOCOL 1'h0
`define RST_STATION 5'h01
`define RST_RATE 9'h060
`define RST_STOP 2'h1
`define RST_PARITY 2'h0
`define RST_TIMEOUT 10'h000
`define RST_DELAY 10'h001
`define RST_GAP 8'h03
`define STATION_MIN 5'h01
`define STATION_MAX 5'h1f
`define TIMEOUT_MAX 10'h258
`define DELAY_MIN 10'h001
`define DELAY_MAX 10'h3e8
`define GAP_MIN 8'h03
`define GAP_MAX 8'hc8
`define RATE_A 9'h030
`define RATE_B 9'h060
`define RATE_C 9'h0c0
`define RATE_D 9'h180
`define CMD_FRAME_END 8'h0d

// ==========================================
// Timing.
`define CLK_HZ 100000000
`define CLK_NS 10
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_NS)
`define TIMEOUT_UNIT_MS 16'h0064

// ==========================================
// Status bits.
`define EV_TIMEOUT 0
`define EV_MATCH 1
`define EV_REPLY 2

`endif

// [serial_link_config_pkg.sv]
package serial_link_config_pkg;

    typedef struct packed {
        logic protocol_select;
        logic [4:0] station_number;
        logic [8:0] bit_rate_code;
        logic [1:0] stop_bit_count;
        logic [1:0] parity_select;
        logic [9:0] link_timeout;
        logic [9:0] reply_delay;
        logic [7:0] frame_end_gap;
    } cfg_set_t;

    typedef struct packed {
        logic protocol_select;
        logic two_stop;
        logic [1:0] parity_select;
        logic [15:0] bit_cycles;
    } frame_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FRAME,
        ST_WAIT
    } link_state_t;

endpackage

// [serial_link_config.sv]
// What this block does
// R1: Protocol 0 command, 1 Modbus RTU.
// R2: Station 1 to 31, answer matching frames.
// R3: Rate codes 48/96/192/384 set bit time.
// R4: One or two stop bits; parity none/odd/even.
// R5: Timeout 0.1-60 s; zero disables it.
// R6: Reply after delay; Modbus ends frames by gap.
// R7: New settings apply only after supply restart.
// R8: Timeout expiry raises a status flag.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "serial_link_config_regs.svh"

module serial_link_config
    import serial_link_config_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYCLES
)
(
    // Clock, reset, enable.
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // Supply restart pulse.
    input wire logic supply_restart,
    // AXI4-Lite write.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Received characters.
    input wire logic rx_byte_valid,
    input wire logic rx_byte_ok,
    input wire logic [7:0] rx_byte,
    // Link control outputs.
    output frame_cfg_t frame_cfg,
    output logic reply_start,
    output logic link_lost,
    output logic irq
);

    // ==========================================
    // Functions.
    function automatic logic [15:0] bit_cycles_of(input logic [8:0] code);
        logic [31:0] rate;
        rate = 32'(code) * 32'd100;
        bit_cycles_of = (rate == 32'h0) ? 16'h0 : 16'(`CLK_HZ / rate);
    endfunction

    function automatic logic rate_ok(input logic [8:0] code);
        rate_ok = (code == `RATE_A) || (code == `RATE_B) || (code == `RATE_C) || (code == `RATE_D);
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic [15:0] cfg_word(input cfg_set_t c, input logic [7:0] a);
        case (a)
            `OFS_PROTOCOL: cfg_word = 16'(c.protocol_select);
            `OFS_STATION: cfg_word = 16'(c.station_number);
            `OFS_RATE: cfg_word = 16'(c.bit_rate_code);
            `OFS_STOP: cfg_word = 16'(c.stop_bit_count);
            `OFS_PARITY: cfg_word = 16'(c.parity_select);
            `OFS_TIMEOUT: cfg_word = 16'(c.link_timeout);
            `OFS_DELAY: cfg_word = 16'(c.reply_delay);
            `OFS_GAP: cfg_word = 16'(c.frame_end_gap);
            default: cfg_word = 16'h0;
        endcase
    endfunction

    // ==========================================
    // Bus slave state.
    cfg_set_t stg_ff;
    cfg_set_t act_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [2:0] irq_stat_ff;
    logic [2:0] irq_mask_ff;
    logic irq_ff;
    logic [2:0] ev;
    logic wr_go;
    logic [15:0] wval;
    logic wr_cfg;
    logic wr_legal;

    assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wval = merge(cfg_word(stg_ff, awaddr_ff), wdata_ff, wstrb_ff);
    assign wr_cfg = (awaddr_ff <= `OFS_GAP) && (awaddr_ff[1:0] == 2'h0);

    always_comb
    begin
        case (awaddr_ff)
            `OFS_PROTOCOL: wr_legal = wval <= 16'h1; // [R1]
            `OFS_STATION: wr_legal = wval >= 16'(`STATION_MIN) && wval <= 16'(`STATION_MAX); // [R2]
            `OFS_RATE: wr_legal = wval[15:9] == 7'h0 && rate_ok(wval[8:0]); // [R3]
            `OFS_STOP: wr_legal = wval == 16'h1 || wval == 16'h2; // [R4]
            `OFS_PARITY: wr_legal = wval <= 16'h2; // [R4]
            `OFS_TIMEOUT: wr_legal = wval <= 16'(`TIMEOUT_MAX); // [R5]
            `OFS_DELAY: wr_legal = wval >= 16'(`DELAY_MIN) && wval <= 16'(`DELAY_MAX); // [R6]
            `OFS_GAP: wr_legal = wval >= 16'(`GAP_MIN) && wval <= 16'(`GAP_MAX); // [R6]
            `OFS_IRQ_STAT, `OFS_IRQ_MASK: wr_legal = 1'b1;
            default: wr_legal = 1'b0;
        endcase
    end

    // ==========================================
    // Write channel handshake.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            awaddr_ff <= 8'h0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && awready_ff)
            begin
                awaddr_ff <= s_axi_awaddr;
                aw_got_ff <= 1'b1;
                awready_ff <= 1'b0;
            end
            if (s_axi_wvalid && wready_ff)
            begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                w_got_ff <= 1'b1;
                wready_ff <= 1'b0;
            end
            if (wr_go)
            begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= (wr_cfg || awaddr_ff == `OFS_IRQ_STAT || awaddr_ff == `OFS_IRQ_MASK)
                    ? (wr_legal ? 2'h0 : 2'h2) : 2'h3;
            end
            if (bvalid_ff && s_axi_bready)
            begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // ==========================================
    // Stored settings and the active copy.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stg_ff <= '{`RST_PROTOCOL, `RST_STATION, `RST_RATE, `RST_STOP, `RST_PARITY,
                        `RST_TIMEOUT, `RST_DELAY, `RST_GAP};
            act_ff <= '{`RST_PROTOCOL, `RST_STATION, `RST_RATE, `RST_STOP, `RST_PARITY,
                        `RST_TIMEOUT, `RST_DELAY, `RST_GAP};
        end
        else if (clk_en)
        begin
            if (supply_restart)
            begin
                act_ff <= stg_ff; // [R7]
            end
            if (wr_go && wr_cfg && wr_legal)
            begin
                case (awaddr_ff)
                    `OFS_PROTOCOL: stg_ff.protocol_select <= wval[0];
                    `OFS_STATION: stg_ff.station_number <= wval[4:0];
                    `OFS_RATE: stg_ff.bit_rate_code <= wval[8:0];
                    `OFS_STOP: stg_ff.stop_bit_count <= wval[1:0];
                    `OFS_PARITY: stg_ff.parity_select <= wval[1:0];
                    `OFS_TIMEOUT: stg_ff.link_timeout <= wval[9:0];
                    `OFS_DELAY: stg_ff.reply_delay <= wval[9:0];
                    `OFS_GAP: stg_ff.frame_end_gap <= wval[7:0];
                    default: stg_ff <= stg_ff;
                endcase
            end
        end
    end

    // ==========================================
    // Interrupt status, mask and line.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat_ff <= 3'h0;
            irq_mask_ff <= 3'h0;
            irq_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_go && awaddr_ff == `OFS_IRQ_STAT)
            begin
                irq_stat_ff <= (irq_stat_ff & ~wdata_ff[2:0]) | ev;
            end
            else
            begin
                irq_stat_ff <= irq_stat_ff | ev;
            end
            if (wr_go && awaddr_ff == `OFS_IRQ_MASK)
            begin
                irq_mask_ff <= wdata_ff[2:0];
            end
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // ==========================================
    // Read channel.
    link_state_t state_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= 2'h0;
        end
        else if (clk_en)
        begin
            if (s_axi_arvalid && arready_ff)
            begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rresp_ff <= 2'h0;
                case (s_axi_araddr)
                    `OFS_ACTIVE: rdata_ff <= {1'b0, act_ff.reply_delay[7:0], act_ff.station_number,
                        act_ff.bit_rate_code, act_ff.stop_bit_count, act_ff.parity_select,
                        act_ff.protocol_select, 3'h0, link_lost};
                    `OFS_LINK: rdata_ff <= {29'h0, link_lost, 2'(state_ff)};
                    `OFS_IRQ_STAT: rdata_ff <= {29'h0, irq_stat_ff};
                    `OFS_IRQ_MASK: rdata_ff <= {29'h0, irq_mask_ff};
                    default:
                    begin
                        rdata_ff <= {16'h0, cfg_word(stg_ff, s_axi_araddr)};
                        if (s_axi_araddr > `OFS_GAP || s_axi_araddr[1:0] != 2'h0)
                        begin
                            rresp_ff <= 2'h3;
                        end
                    end
                endcase
            end
            if (rvalid_ff && s_axi_rready)
            begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    // ==========================================
    // Millisecond tick and link framing.
    logic [31:0] ms_cnt_ff;
    logic tick_ff;
    logic rx_good;
    logic [7:0] gap_cnt_ff;
    logic [9:0] dly_cnt_ff;
    logic hit_ff;
    logic reply_ff;
    logic match_ev_ff;
    logic frame_end;

    assign rx_good = rx_byte_valid && rx_byte_ok;
    assign frame_end = act_ff.protocol_select
        ? (tick_ff && gap_cnt_ff + 8'h1 >= act_ff.frame_end_gap) // [R6]
        : (rx_good && rx_byte == `CMD_FRAME_END); // [R1]

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ms_cnt_ff <= 32'h0;
            tick_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            tick_ff <= ms_cnt_ff == 32'(MS_CYCLES - 1);
            ms_cnt_ff <= (ms_cnt_ff == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff <= ST_IDLE;
            gap_cnt_ff <= 8'h0;
            dly_cnt_ff <= 10'h0;
            hit_ff <= 1'b0;
            reply_ff <= 1'b0;
            match_ev_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            reply_ff <= 1'b0;
            match_ev_ff <= 1'b0;
            case (state_ff)
                ST_IDLE:
                begin
                    if (rx_good)
                    begin
                        hit_ff <= rx_byte == 8'(act_ff.station_number); // [R2]
                        gap_cnt_ff <= 8'h0;
                        state_ff <= ST_FRAME;
                    end
                end
                ST_FRAME:
                begin
                    if (rx_good && !frame_end)
                    begin
                        gap_cnt_ff <= 8'h0;
                    end
                    else if (tick_ff)
                    begin
                        gap_cnt_ff <= gap_cnt_ff + 8'h1;
                    end
                    if (frame_end)
                    begin
                        dly_cnt_ff <= 10'h0;
                        match_ev_ff <= hit_ff;
                        state_ff <= hit_ff ? ST_WAIT : ST_IDLE; // [R2]
                    end
                end
                ST_WAIT:
                begin
                    if (tick_ff)
                    begin
                        dly_cnt_ff <= dly_cnt_ff + 10'h1;
                        if (dly_cnt_ff + 10'h1 >= act_ff.reply_delay)
                        begin
                            reply_ff <= 1'b1; // [R6]
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end


    // ==========================================
    // Loss-of-link timer.
    logic [15:0] to_cnt_ff;
    logic lost_ff;
    logic to_ev_ff;
    logic [15:0] to_limit;

    assign to_limit = 16'(act_ff.link_timeout) * `TIMEOUT_UNIT_MS;
    assign ev = {reply_ff, match_ev_ff, to_ev_ff};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            to_cnt_ff <= 16'h0;
            lost_ff <= 1'b0;
            to_ev_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            to_ev_ff <= 1'b0;
            if (rx_good)
            begin
                to_cnt_ff <= 16'h0;
                lost_ff <= 1'b0;
            end
            else if (tick_ff && to_limit != 16'h0 && !lost_ff) // [R5]
            begin
                to_cnt_ff <= to_cnt_ff + 16'h1;
                if (to_cnt_ff + 16'h1 >= to_limit)
                begin
                    lost_ff <= 1'b1;
                    to_ev_ff <= 1'b1; // [R8]
                end
            end
        end
    end

    // ==========================================
    // Character framing output.
    frame_cfg_t fc_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fc_ff <= '0;
        end
        else if (clk_en)
        begin
            fc_ff.protocol_select <= act_ff.protocol_select; // [R1]
            fc_ff.two_stop <= act_ff.stop_bit_count == 2'h2; // [R4]
            fc_ff.parity_select <= act_ff.parity_select; // [R4]
            fc_ff.bit_cycles <= bit_cycles_of(act_ff.bit_rate_code); // [R3]
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign frame_cfg = fc_ff;
    assign reply_start = reply_ff;
    assign link_lost = lost_ff;
    assign irq = irq_ff;

    // ==========================================
    // Checks.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    proto_legal_a: assert property (wr_go && awaddr_ff == `OFS_PROTOCOL && wval > 16'h1 // [R1]
        |=> $stable(stg_ff.protocol_select)) else $error("protocol bad");
    station_range_a: assert property (stg_ff.station_number >= `STATION_MIN) else $error("station out"); // [R2]
    rate_div_a: assert property (clk_en && act_ff.bit_rate_code == `RATE_B ##1 1
        |-> fc_ff.bit_cycles == 16'd10416) else $error("bit time wrong"); // [R3]
    stop_cfg_a: assert property (clk_en |=> fc_ff.two_stop == ($past(act_ff.stop_bit_count) == 2'h2))
        else $error("stop bits wrong"); // [R4]
    timeout_off_a: assert property ($rose(lost_ff) |-> $past(to_limit) != 16'h0)
        else $error("timeout while off"); // [R5]
    reply_cause_a: assert property ($rose(reply_ff) |-> $past(state_ff) == ST_WAIT && $past(tick_ff))
        else $error("reply early"); // [R6]
    active_hold_a: assert property (clk_en && !supply_restart |=> act_ff == $past(act_ff))
        else $error("active changed"); // [R7]
    timeout_flag_a: assert property (clk_en && to_ev_ff |=> irq_stat_ff[`EV_TIMEOUT])
        else $error("flag lost"); // [R8]

    reply_seen_c: cover property ($rose(reply_ff));
    lost_seen_c: cover property ($rose(lost_ff));
    restart_seen_c: cover property (clk_en && supply_restart && stg_ff != act_ff);

endmodule

// [remote_host.sv]
`timescale 1ns/1ps

// ==========================================
// Remote host that hands received characters to the device.
module remote_host
(
    // Clock.
    input wire logic aclk,
    // Characters toward the device.
    output logic rx_byte_valid,
    output logic rx_byte_ok,
    output logic [7:0] rx_byte
);
    initial
    begin
        rx_byte_valid = 1'b0;
        rx_byte_ok = 1'b0;
        rx_byte = 8'h00;
    end

    // Sends one character for one cycle with the given ok flag, then stays idle for idle+1 cycles; idle data keeps changing.
    task send_char(input logic [7:0] b, input logic ok, input int idle);
        @(posedge aclk);
        rx_byte_valid <= 1'b1;
        rx_byte_ok <= ok;
        rx_byte <= b;
        repeat (idle + 1)
        begin
            @(posedge aclk);
            rx_byte_valid <= 1'b0;
            rx_byte_ok <= ~ok;
            rx_byte <= rx_byte + 8'h35;
        end
    endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`include "serial_link_config_regs.svh"

// ==========================================
// Self-checking bench.
module tb_top
    import serial_link_config_pkg::*;
;
    localparam int MS = 20;
    localparam logic [7:0] OFS [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
    localparam logic [31:0] DFLT [8] = '{32'h0, 32'h1, 32'h60, 32'h1, 32'h0, 32'h0, 32'h1, 32'h3};
    localparam logic [7:0] BAD_A [12] = '{8'h00, 8'h04, 8'h04, 8'h08, 8'h0c, 8'h0c, 8'h10, 8'h14, 8'h18,
        8'h18, 8'h1c, 8'h1c};
    localparam logic [31:0] BAD_D [12] = '{32'h2, 32'h0, 32'h20, 32'h64, 32'h0, 32'h3, 32'h3, 32'h259,
        32'h0, 32'h3e9, 32'h2, 32'hc9};
    localparam logic [8:0] RATES [4] = '{9'h030, 9'h060, 9'h0c0, 9'h180};
    logic aclk, aresetn, clk_en, supply_restart;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rx_byte;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, sb, pr;
    logic rx_byte_valid, rx_byte_ok, reply_start, link_lost, irq, p;
    logic [4:0] st;
    logic [8:0] rt;
    frame_cfg_t frame_cfg, exp_cfg;
    int n_fail, cmp_count, cyc, n;

    serial_link_config #(.MS_CYCLES(MS)) dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .supply_restart(supply_restart), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .rx_byte_valid(rx_byte_valid), .rx_byte_ok(rx_byte_ok), .rx_byte(rx_byte), .frame_cfg(frame_cfg),
        .reply_start(reply_start), .link_lost(link_lost), .irq(irq));
    remote_host host (.aclk(aclk), .rx_byte_valid(rx_byte_valid), .rx_byte_ok(rx_byte_ok), .rx_byte(rx_byte));

    always #5 aclk = ~aclk;

    // ==========================================
    // Checking and reporting.
    task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task win(input string name, input int v, input int lo, input int hi);
        chk(name, 32'(v >= lo && v <= hi), 32'h1);
    endtask

    task results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic logic [15:0] bits_of(input logic [8:0] code);
        return 16'(`CLK_HZ / (int'(code) * 100));
    endfunction

    // ==========================================
    // Register bus master.
    task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(s_axi_bresp), 32'(er));
    endtask

    task axr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task rdx(input logic [7:0] a, input logic [31:0] exp);
        axr(a);
        chk("rdata", rd, exp);
        chk("rresp", 32'(rsp), 32'h0);
    endtask

    task cfg(input logic pp, input logic [4:0] s, input int dl, input int tm);
        axw(`OFS_PROTOCOL, 32'(pp), 2'h0);
        axw(`OFS_STATION, 32'(s), 2'h0);
        axw(`OFS_DELAY, 32'(dl), 2'h0);
        axw(`OFS_TIMEOUT, 32'(tm), 2'h0);
        @(posedge aclk);
        supply_restart <= 1'b1;
        @(posedge aclk);
        supply_restart <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    task wait_ev(input bit sel, input int lim);
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end while ((sel ? link_lost : reply_start) !== 1'b1 && n < lim);
    endtask

    // ==========================================
    // Main sequence.
    initial
    begin
        {aclk, aresetn, supply_restart, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        clk_en = 1'b1;
        s_axi_wstrb = 4'hf;
        {n_fail, cmp_count, cyc} = '0;
        void'($urandom(28335));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        exp_cfg = '{1'b0, 1'b0, 2'h0, bits_of(9'h060)};
        foreach (OFS[i]) rdx(OFS[i], DFLT[i]);
        chk("frame_cfg", 32'(frame_cfg), 32'(exp_cfg));
        foreach (BAD_A[i]) axw(BAD_A[i], BAD_D[i], 2'h2);
        rdx(`OFS_STATION, 32'h1);
        axw(8'h30, 32'h0, 2'h3);
        axr(8'h30);
        chk("unmapped", {rd[29:0], rsp}, 32'h3);
        repeat (3)
        begin
            p = 1'($urandom_range(1));
            st = 5'($urandom_range(31, 1));
            rt = RATES[$urandom_range(3)];
            sb = 2'($urandom_range(2, 1));
            pr = 2'($urandom_range(2));
            axw(`OFS_RATE, 32'(rt), 2'h0);
            axw(`OFS_STOP, 32'(sb), 2'h0);
            axw(`OFS_PARITY, 32'(pr), 2'h0);
            rdx(`OFS_RATE, 32'(rt));
            chk("held", 32'(frame_cfg), 32'(exp_cfg));
            cfg(p, st, 1, 0);
            exp_cfg = '{p, sb == 2'h2, pr, bits_of(rt)};
            chk("frame_cfg", 32'(frame_cfg), 32'(exp_cfg));
            axr(`OFS_ACTIVE);
            chk("active", rd, {1'b0, 8'h01, st, rt, sb, pr, p, 4'h0});
        end
        cfg(1'b0, st, 2, 0);
        axw(`OFS_IRQ_MASK, 32'h7, 2'h0);
        axw(`OFS_IRQ_STAT, 32'h7, 2'h0);
        repeat (2100) @(posedge aclk);
        chk("timeout off", 32'(link_lost), 32'h0);
        host.send_char({3'h0, st ^ 5'h01}, 1'b1, 2);
        host.send_char(`CMD_FRAME_END, 1'b1, 0);
        wait_ev(1'b0, 100);
        chk("foreign", 32'(n), 32'd100);
        host.send_char({3'h0, st}, 1'b1, 2);
        host.send_char(`CMD_FRAME_END, 1'b0, 2);
        host.send_char(8'h41, 1'b1, 2);
        host.send_char(`CMD_FRAME_END, 1'b1, 0);
        wait_ev(1'b0, 200);
        win("reply wait", n, MS - 5, 2 * MS + 10);
        repeat (2) @(posedge aclk);
        chk("irq", 32'(irq), 32'h1);
        rdx(`OFS_IRQ_STAT, 32'h6);
        axw(`OFS_IRQ_STAT, 32'h6, 2'h0);
        rdx(`OFS_IRQ_STAT, 32'h0);
        axw(`OFS_IRQ_MASK, 32'h0, 2'h0);
        host.send_char({3'h0, st}, 1'b1, 0);
        host.send_char(`CMD_FRAME_END, 1'b1, 0);
        wait_ev(1'b0, 200);
        repeat (2) @(posedge aclk);
        chk("masked irq", 32'(irq), 32'h0);
        rdx(`OFS_IRQ_STAT, 32'h6);
        axw(`OFS_GAP, 32'h5, 2'h0);
        cfg(1'b1, st, 1, 0);
        host.send_char({3'h0, st}, 1'b1, 5);
        host.send_char(`CMD_FRAME_END, 1'b1, 5);
        host.send_char(8'h03, 1'b1, 0);
        wait_ev(1'b0, 300);
        win("gap end", n, 5 * MS, 6 * MS + 10);
        cfg(1'b0, st, 1, 1);
        axw(`OFS_IRQ_STAT, 32'h7, 2'h0);
        axw(`OFS_IRQ_MASK, 32'h1, 2'h0);
        host.send_char(8'h00, 1'b1, 0);
        clk_en <= 1'b0;
        repeat (500) @(posedge aclk);
        clk_en <= 1'b1;
        wait_ev(1'b1, 2500);
        win("timeout", n, 99 * MS - 5, 100 * MS + 10);
        repeat (2) @(posedge aclk);
        chk("timeout irq", 32'(irq), 32'h1);
        rdx(`OFS_IRQ_STAT, 32'h1);
        rdx(`OFS_LINK, 32'h5);
        host.send_char(8'h00, 1'b0, 2);
        chk("bad char", 32'(link_lost), 32'h1);
        host.send_char(8'h00, 1'b1, 2);
        chk("good char", 32'(link_lost), 32'h0);
        results();
    end

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_fail++;
            results();
        end
    end
endmodule
